// ===== fdpi_pkg.sv
// package for the floppy drive pin interface
package fdpi_pkg;
    // data rate codes
    localparam logic [1:0] FDPI_RATE_500K = 2'h0;
    localparam logic [1:0] FDPI_RATE_300K = 2'h1;
    localparam logic [1:0] FDPI_RATE_250K = 2'h2;
    localparam logic [1:0] FDPI_RATE_1M   = 2'h3;
    // thermal host enable field position and reset values
    localparam int         FDPI_ETS_LSB   = 4;
    localparam int         FDPI_ETS_MSB   = 6;
    localparam logic [7:0] FDPI_CFG_RST   = 8'h00;
    localparam logic       FDPI_OUT_RST   = 1'b1;
    localparam logic       FDPI_DENS_RST  = 1'b0;
    localparam logic       FDPI_DIR_RST   = 1'b1;
    localparam logic       FDPI_ETS_RST   = 1'b0;
    localparam logic       FDPI_STS_RST   = 1'b0;

    // controller-side drive requests, active high
    typedef struct packed {
        logic [1:0] rate;
        logic       motor_a;
        logic       motor_b;
        logic       sel_a;
        logic       sel_b;
        logic       dir_out;
        logic       step;
        logic       side1;
        logic       write_gate_n;
        logic       wdata;
    } fdpi_ctl_t;

    // drive status seen by controller, active high
    typedef struct packed {
        logic rdata;
        logic track0;
        logic index;
        logic wprot;
        logic dchg;
    } fdpi_sts_t;
endpackage

// ===== fdpi_outreg.sv
// registered active-low output with clock enable
`timescale 1ns/1ps
module fdpi_outreg
    import fdpi_pkg::*;
(
    input  wire logic CLK,
    input  wire logic RESET,
    input  wire logic CE,
    input  wire logic ACT,
    output logic      PIN_N
);
    logic q_q;
    logic q_d;

    // invert the active-high request
    always_comb begin
        q_d = ~ACT;
    end

    // register, idle high after reset
    always_ff @(posedge CLK) begin
        if (RESET) begin
            q_q <= FDPI_OUT_RST;
        end else if (CE) begin
            q_q <= q_d;
        end
    end

    assign PIN_N = q_q;
endmodule

// ===== fdpi_top.sv
// floppy drive pin interface with shared thermal pins
`timescale 1ns/1ps
module fdpi_top
    import fdpi_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RESET,
    input  wire logic       CE,
    input  wire fdpi_ctl_t  CTL,
    output fdpi_sts_t       STS,
    input  wire logic [7:0] ETS_CFG,
    input  wire logic       SENSOR_DATA_O,
    input  wire logic       SENSOR_DATA_OE,
    output logic            SENSOR_DATA_I,
    input  wire logic       SENSOR_CLOCK_O,
    input  wire logic       SENSOR_CLOCK_OE,
    output logic            DENSITY_SELECT_N,
    output logic            MOTOR_ENABLE_A_N,
    output logic            DRIVE_SELECT_A_N,
    output logic            WRITE_DATA_N,
    output logic            DIRECTION_N,
    output logic            STEP_N,
    output logic            HEAD_SIDE_SEL_N,
    output logic            WRITE_GATE_N,
    input  wire logic       READ_DATA_N,
    input  wire logic       OUTER_TRACK_N,
    input  wire logic       TRACK_START_N,
    input  wire logic       WRITE_PROTECTED_N,
    input  wire logic       MEDIA_CHANGED_N,
    input  wire logic       MOTOR_B_PIN_I,
    output logic            MOTOR_B_PIN_O,
    output logic            MOTOR_B_PIN_OE,
    input  wire logic       DRIVE_B_PIN_I,
    output logic            DRIVE_B_PIN_O,
    output logic            DRIVE_B_PIN_OE
);
    // density select state
    logic       dens_d;
    logic       dens_q;
    // head direction state
    logic       dir_d;
    logic       dir_q;
    // thermal host enable state
    logic       ets_d;
    logic       ets_q;
    // sensed drive inputs, one flop each
    logic       rdata_d;
    logic       rdata_q;
    logic       track0_d;
    logic       track0_q;
    logic       index_d;
    logic       index_q;
    logic       wprot_d;
    logic       wprot_q;
    logic       dchg_d;
    logic       dchg_q;
    // floppy-side levels of the two shared pins
    logic       motor_enable_b_n_n;
    logic       drive_select_b_n_n;
    // sensor clock pin input has no reader yet
    logic       unused_drive_select_b_n;

    // motor enable for drive A, idle high
    fdpi_outreg u_motor_a (
        .CLK   (CLK),
        .RESET (RESET),
        .CE    (CE),
        .ACT   (CTL.motor_a),
        .PIN_N (MOTOR_ENABLE_A_N)
    );

    // drive select for drive A, idle high
    fdpi_outreg u_select_a (
        .CLK   (CLK),
        .RESET (RESET),
        .CE    (CE),
        .ACT   (CTL.sel_a),
        .PIN_N (DRIVE_SELECT_A_N)
    );

    // serial write data, inverted on the pin
    fdpi_outreg u_write_data (
        .CLK   (CLK),
        .RESET (RESET),
        .CE    (CE),
        .ACT   (CTL.wdata),
        .PIN_N (WRITE_DATA_N)
    );

    // head step pulse, one cycle low per request cycle
    fdpi_outreg u_step (
        .CLK   (CLK),
        .RESET (RESET),
        .CE    (CE),
        .ACT   (CTL.step),
        .PIN_N (STEP_N)
    );

    // head side select
    fdpi_outreg u_side (
        .CLK   (CLK),
        .RESET (RESET),
        .CE    (CE),
        .ACT   (CTL.side1),
        .PIN_N (HEAD_SIDE_SEL_N)
    );

    // write gate, low while writing
    fdpi_outreg u_write_gate (
        .CLK   (CLK),
        .RESET (RESET),
        .CE    (CE),
        .ACT   (CTL.write_gate_n),
        .PIN_N (WRITE_GATE_N)
    );

    // motor enable for drive B, floppy level of the shared pin
    fdpi_outreg u_motor_b (
        .CLK   (CLK),
        .RESET (RESET),
        .CE    (CE),
        .ACT   (CTL.motor_b),
        .PIN_N (motor_enable_b_n_n)
    );

    // drive select for drive B, floppy level of the shared pin
    fdpi_outreg u_select_b (
        .CLK   (CLK),
        .RESET (RESET),
        .CE    (CE),
        .ACT   (CTL.sel_b),
        .PIN_N (drive_select_b_n_n)
    );

    // density: high for the fast rates, low for the slow ones
    always_comb begin
        case (CTL.rate)
            FDPI_RATE_500K: dens_d = 1'h1;
            FDPI_RATE_1M:   dens_d = 1'h1;
            FDPI_RATE_300K: dens_d = 1'h0;
            FDPI_RATE_250K: dens_d = 1'h0;
            default:        dens_d = 1'h0;
        endcase
    end

    // density register, frozen while CE is low
    always_ff @(posedge CLK) begin
        if (RESET) begin
            dens_q <= FDPI_DENS_RST;
        end else if (CE) begin
            dens_q <= dens_d;
        end
    end

    assign DENSITY_SELECT_N = dens_q;

    // direction: low steps in, high steps out
    always_comb begin
        dir_d = CTL.dir_out;
    end

    // direction register, outward after reset
    always_ff @(posedge CLK) begin
        if (RESET) begin
            dir_q <= FDPI_DIR_RST;
        end else if (CE) begin
            dir_q <= dir_d;
        end
    end

    assign DIRECTION_N = dir_q;

    // thermal host enabled when any enable bit is set
    always_comb begin
        ets_d = |ETS_CFG[FDPI_ETS_MSB:FDPI_ETS_LSB];
    end

    // host enable register, floppy function after reset
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ets_q <= FDPI_ETS_RST;
        end else if (CE) begin
            ets_q <= ets_d;
        end
    end

    // read data stream, made active high
    always_comb begin
        rdata_d = ~READ_DATA_N;
    end

    // read data flop
    always_ff @(posedge CLK) begin
        if (RESET) begin
            rdata_q <= FDPI_STS_RST;
        end else if (CE) begin
            rdata_q <= rdata_d;
        end
    end

    // outer track sense, made active high
    always_comb begin
        track0_d = ~OUTER_TRACK_N;
    end

    // outer track flop
    always_ff @(posedge CLK) begin
        if (RESET) begin
            track0_q <= FDPI_STS_RST;
        end else if (CE) begin
            track0_q <= track0_d;
        end
    end

    // track start pulse, made active high
    always_comb begin
        index_d = ~TRACK_START_N;
    end

    // track start flop
    always_ff @(posedge CLK) begin
        if (RESET) begin
            index_q <= FDPI_STS_RST;
        end else if (CE) begin
            index_q <= index_d;
        end
    end

    // write protect sense, made active high
    always_comb begin
        wprot_d = ~WRITE_PROTECTED_N;
    end

    // write protect flop
    always_ff @(posedge CLK) begin
        if (RESET) begin
            wprot_q <= FDPI_STS_RST;
        end else if (CE) begin
            wprot_q <= wprot_d;
        end
    end

    // media change sense, made active high
    always_comb begin
        dchg_d = ~MEDIA_CHANGED_N;
    end

    // media change flop
    always_ff @(posedge CLK) begin
        if (RESET) begin
            dchg_q <= FDPI_STS_RST;
        end else if (CE) begin
            dchg_q <= dchg_d;
        end
    end

    // status bundle to the controller, active high
    assign STS.rdata  = rdata_q;
    assign STS.track0 = track0_q;
    assign STS.index  = index_q;
    assign STS.wprot  = wprot_q;
    assign STS.dchg   = dchg_q;

    // motor-B shared pin: sensor data wins when host enabled
    always_comb begin
        if (ets_q) begin
            MOTOR_B_PIN_O  = SENSOR_DATA_O;
            MOTOR_B_PIN_OE = SENSOR_DATA_OE;
            SENSOR_DATA_I  = MOTOR_B_PIN_I;
        end else begin
            MOTOR_B_PIN_O  = motor_enable_b_n_n;
            MOTOR_B_PIN_OE = 1'h1;
            SENSOR_DATA_I  = 1'h1;
        end
    end

    // drive-B shared pin: sensor clock wins when host enabled
    always_comb begin
        if (ets_q) begin
            DRIVE_B_PIN_O  = SENSOR_CLOCK_O;
            DRIVE_B_PIN_OE = SENSOR_CLOCK_OE;
        end else begin
            DRIVE_B_PIN_O  = drive_select_b_n_n;
            DRIVE_B_PIN_OE = 1'h1;
        end
    end

    // clock pin input is not used by any function here
    assign unused_drive_select_b_n = DRIVE_B_PIN_I;
endmodule

// ===== fdpi_properties.sv
// assertions on the floppy pin outputs
`timescale 1ns/1ps
module fdpi_properties import fdpi_pkg::*; (
    input wire logic       CLK,
    input wire logic       RESET,
    input wire logic       CE,
    input wire fdpi_ctl_t  CTL,
    input wire logic [7:0] ETS_CFG,
    input wire logic       SENSOR_DATA_O,
    input wire logic       SENSOR_CLOCK_O,
    input wire logic       DENSITY_SELECT_N,
    input wire logic       MOTOR_ENABLE_A_N,
    input wire logic       DRIVE_SELECT_A_N,
    input wire logic       WRITE_DATA_N,
    input wire logic       DIRECTION_N,
    input wire logic       STEP_N,
    input wire logic       HEAD_SIDE_SEL_N,
    input wire logic       WRITE_GATE_N,
    input wire logic       MOTOR_B_PIN_O,
    input wire logic       MOTOR_B_PIN_OE,
    input wire logic       DRIVE_B_PIN_O
);
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // floppy outputs follow the request one cycle later; host-enabled B pins follow sensor outputs at once
    dens_sel_a: assert property (CE |=> DENSITY_SELECT_N == ~^$past(CTL.rate))
        else $error("density wrong");
    drive_a_a: assert property (CE |=> {MOTOR_ENABLE_A_N, DRIVE_SELECT_A_N}
        == ~$past({CTL.motor_a, CTL.sel_a})) else $error("drive a wrong");
    write_pins_a: assert property (CE |=> {WRITE_DATA_N, WRITE_GATE_N}
        == ~$past({CTL.wdata, CTL.write_gate_n})) else $error("write wrong");
    dir_lvl_a: assert property (CE |=> DIRECTION_N == $past(CTL.dir_out))
        else $error("direction wrong");
    step_side_a: assert property (CE |=> {STEP_N, HEAD_SIDE_SEL_N}
        == ~$past({CTL.step, CTL.side1})) else $error("step wrong");
    b_floppy_a: assert property (CE && ETS_CFG[6:4] == 3'h0 |=> MOTOR_B_PIN_OE &&
        {MOTOR_B_PIN_O, DRIVE_B_PIN_O} == ~$past({CTL.motor_b, CTL.sel_b})) else $error("b pins");
    b_data_a: assert property (CE && ETS_CFG[6:4] != 3'h0 ##1 $stable(SENSOR_DATA_O)
        |-> MOTOR_B_PIN_O == SENSOR_DATA_O) else $error("sensor data");
    b_clock_a: assert property (CE && ETS_CFG[6:4] != 3'h0 ##1 $stable(SENSOR_CLOCK_O)
        |-> DRIVE_B_PIN_O == SENSOR_CLOCK_O) else $error("sensor clock");
    // main scenarios reached
    cover property (CE && CTL.step);
    cover property (CE && CTL.write_gate_n);
    cover property (CE && ETS_CFG[6:4] != 3'h0);
endmodule

// ===== fdpi_drive_model.sv
// behavioural floppy drive on the far side
`timescale 1ns/1ps
module fdpi_drive_model (
    input wire logic CLK,
    input wire logic STEP_N,
    input wire logic DIRECTION_N,
    input wire logic WRITE_DATA_N,
    input wire logic PROT,
    input wire logic SWAP,
    output logic     READ_DATA_N,
    output logic     OUTER_TRACK_N,
    output logic     TRACK_START_N,
    output logic     WRITE_PROTECTED_N,
    output logic     MEDIA_CHANGED_N
);
    int         trk = 2;
    logic [3:0] rev = 4'h0;
    // head moves on each falling step edge
    always @(negedge STEP_N) trk <= DIRECTION_N ? (trk > 0 ? trk - 1 : 0) : trk + 1;
    always @(posedge CLK) rev <= rev + 4'h1;
    // status lines, all active low
    assign READ_DATA_N = WRITE_DATA_N;
    assign OUTER_TRACK_N = trk != 0;
    assign TRACK_START_N = rev != 4'h0;
    assign WRITE_PROTECTED_N = !PROT;
    assign MEDIA_CHANGED_N = !SWAP;
endmodule

// ===== tb_fdpi_top.sv
// self-checking bench for the floppy pin interface
`timescale 1ns/1ps
module tb_fdpi_top import fdpi_pkg::*; ;
    logic CLK = 0, RESET = 1, CE = 1, PROT = 0, SWAP = 0, EXT_DAT = 1;
    logic SENSOR_DATA_O = 0, SENSOR_DATA_OE = 0, SENSOR_CLOCK_O = 0, SENSOR_CLOCK_OE = 0;
    logic SENSOR_DATA_I, DENSITY_SELECT_N, MOTOR_ENABLE_A_N, DRIVE_SELECT_A_N, WRITE_DATA_N;
    logic DIRECTION_N, STEP_N, HEAD_SIDE_SEL_N, WRITE_GATE_N, READ_DATA_N, OUTER_TRACK_N;
    logic TRACK_START_N, WRITE_PROTECTED_N, MEDIA_CHANGED_N, MOTOR_B_PIN_I, MOTOR_B_PIN_O;
    logic MOTOR_B_PIN_OE, DRIVE_B_PIN_I, DRIVE_B_PIN_O, DRIVE_B_PIN_OE;
    logic [7:0] ETS_CFG = 8'h00;
    fdpi_ctl_t  CTL = '0;
    fdpi_sts_t  STS;
    int         fails = 0, total_checks = 0, cyc = 0;
    fdpi_top fdpi_top_inst (.*);
    fdpi_drive_model fdpi_drive_model_inst (.*);
    // shared pins: driven level, else sensor or pull-up
    assign MOTOR_B_PIN_I = MOTOR_B_PIN_OE ? MOTOR_B_PIN_O : EXT_DAT;
    assign DRIVE_B_PIN_I = DRIVE_B_PIN_OE ? DRIVE_B_PIN_O : 1'b1;
    initial forever #2 CLK = ~CLK;
    task go(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task chk(input string n, input logic e, input logic s);
        total_checks++;
        if (s !== e) begin
            fails++;
            $display("unexpected %s exp %b got %b", n, e, s);
        end
    endtask
    task test_done;
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task t_rates;
        for (int r = 0; r < 4; r++) begin
            CTL.rate = r[1:0];
            go(1);
            chk("dens", CTL.rate inside {FDPI_RATE_500K, FDPI_RATE_1M}, DENSITY_SELECT_N);
        end
    endtask
    task pulse(input logic d);
        CTL.dir_out = d;
        go(1);
        chk("dir", d, DIRECTION_N);
        CTL.step = 1;
        go(1);
        chk("step", 0, STEP_N);
        CTL.step = 0;
        go(2);
    endtask
    task t_seek;
        pulse(1);
        pulse(1);
        chk("outer_track_n", 1, STS.track0);
        pulse(0);
        chk("outer_track_n", 0, STS.track0);
    endtask
    task t_write;
        CTL.motor_a = 1;
        CTL.sel_a = 1;
        CTL.write_gate_n = 1;
        CTL.wdata = 1;
        CTL.side1 = 1;
        go(1);
        chk("mota", 0, MOTOR_ENABLE_A_N);
        chk("sela", 0, DRIVE_SELECT_A_N);
        chk("gate", 0, WRITE_GATE_N);
        chk("side", 0, HEAD_SIDE_SEL_N);
        go(1);
        chk("rdat", 1, STS.rdata);
        CTL.wdata = 0;
        go(2);
        chk("rdat", 0, STS.rdata);
    endtask
    task t_media;
        PROT = 1;
        SWAP = 1;
        go(2);
        chk("wpt", 1, STS.wprot);
        chk("chg", 1, STS.dchg);
    endtask
    task t_therm;
        CTL.motor_b = 1;
        CTL.sel_b = 1;
        go(1);
        chk("motb", 0, MOTOR_B_PIN_O);
        chk("selb", 0, DRIVE_B_PIN_O);
        ETS_CFG = 8'h40;
        SENSOR_DATA_O = 1;
        SENSOR_CLOCK_O = 1;
        EXT_DAT = 0;
        go(2);
        chk("sdat", 1, MOTOR_B_PIN_O);
        chk("sclk", 1, DRIVE_B_PIN_O);
        chk("sin", 0, SENSOR_DATA_I);
    endtask
    task t_freeze;
        CE = 0;
        CTL.motor_a = 0;
        go(2);
        chk("hold", 0, MOTOR_ENABLE_A_N);
        CE = 1;
        go(1);
        chk("mota", 1, MOTOR_ENABLE_A_N);
    endtask
    task t_index;
        int seen;
        seen = 0;
        repeat (16) begin
            go(1);
            if (STS.index === 1'b1) seen++;
        end
        chk("index", 1, seen == 1);
    endtask
    task t_reset;
        RESET = 1;
        go(2);
        chk("motb oe", 1, MOTOR_B_PIN_OE);
        chk("drive_select_b_n oe", 1, DRIVE_B_PIN_OE);
        chk("motb rst", 1, MOTOR_B_PIN_O);
        RESET = 0;
        go(1);
        chk("motb sen", 0, MOTOR_B_PIN_OE);
        chk("drive_select_b_n sen", 0, DRIVE_B_PIN_OE);
    endtask
    // hang guard
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            test_done;
        end
    end
    initial begin
        go(6);
        RESET = 0;
        chk("rst", 1, MOTOR_ENABLE_A_N);
        t_rates;
        t_seek;
        t_write;
        t_media;
        t_freeze;
        t_index;
        t_therm;
        t_reset;
        test_done;
    end
endmodule
bind fdpi_top fdpi_properties fdpi_properties_inst (.*);
